// >>> core/esp_ctrl.sv
// external sram controller: pin sequencing, mux, strobes, read capture
// What this block does
// - bus clock can run only during chip select
// - timing bit picks early or late clock
// - lowest valid address bit on pin zero
// - 32-bit uses bits 28:2, 16-bit 27:1
// - external space spans 256 megabytes
// - sharing bit: 0 separate, 1 multiplexed
// - width bit: 0 16-bit, 1 32-bit
// - address pins driven in every mode
// - 32-bit mux sends padded word address first
// - 16-bit mux sends address 16:1 first
// - hold bit stretches the write strobe
// - async reads sampled on falling clock edge
`timescale 1ns/1ps
`include "esp_cfg.svh"
module esp_ctrl import esp_pkg::*; (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // mode settings
  input  wire esp_mode_t mode_i,
  // request side
  input  wire logic req_valid_i,
  input  wire esp_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [31:0] rsp_rdata_o,
  // memory pins
  output logic ext_bus_clock_o,
  output logic [3:0] chip_select_n_o,
  output logic [`ESP_APIN_W-1:0] ext_addr_pins_o,
  output logic [`ESP_DPIN_W-1:0] ext_data_pins_o,
  output logic [`ESP_DPIN_W-1:0] ext_data_pins_oe_o,
  input  wire logic [`ESP_DPIN_W-1:0] ext_data_pins_i,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic addr_valid_n_o
);
  esp_state_t state_q, state_d; // bus cycle state
  esp_req_t req_q; // latched request
  logic mux_q, wide_q, hold_q, async_q; // modes frozen per access
  logic [2:0] cnt_q; // strobe cycle counter
  logic [`ESP_APIN_W-1:0] apin; // mapped address pins
  logic [`ESP_DPIN_W-1:0] mux_word; // address word for mux phase
  logic [`ESP_DPIN_W-1:0] rd_neg_q; // falling edge capture
  logic [`ESP_DPIN_W-1:0] half_mask; // active data lanes
  logic [`ESP_DPIN_W-1:0] drv_mask; // lanes driven this cycle
  esp_req_t cur_req; // request as the pins see it this cycle
  logic cur_wide; // bus width as the pins see it this cycle
  logic in_win; // address inside external space
  logic take; // request taken
  logic strb_last, hold_last; // counter end points

  assign take = req_valid_i && req_ready_o;
  // only 1000_0000h..1FFF_FFFFh starts a bus cycle
  assign in_win =
    req_i.addr[`ESP_WIN_TOP_MSB:`ESP_WIN_TOP_LSB] == `ESP_WIN_BASE;
  assign strb_last = cnt_q == (`ESP_DATA_CYC - 3'h1);
  assign hold_last = cnt_q == (`ESP_HOLD_CYC - 3'h1);
  assign req_ready_o = state_q == ST_IDLE;
  // 16-bit bus keeps upper lanes off
  assign half_mask = wide_q ? 32'hFFFFFFFF : 32'h0000FFFF;
  // on the take edge the pins follow the new request, not the stale copy
  assign cur_req = take ? req_i : req_q;
  assign cur_wide = take ? mode_i.wide_bus_select : wide_q;
  assign drv_mask = cur_wide ? 32'hFFFFFFFF : 32'h0000FFFF;

  // address pin mapping per bus width
  esp_addr_map u_map (
    .addr_i     (cur_req.addr),
    .wide_i     (cur_wide),
    .apin_o     (apin),
    .mux_word_o (mux_word)
  );

  // bus clock with chip-select gating
  esp_clk_gen u_clk (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .gate_en_i       (mode_i.clk_gate_en),
    .late_i          (mode_i.clock_timing_select),
    .cs_act_i        (state_q != ST_IDLE),
    .ext_bus_clock_o (ext_bus_clock_o)
  );

  // next state of the bus cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take && in_win) begin
          // mux mode inserts the address phase
          state_d = mode_i.pin_sharing_select ? ST_ADDR : ST_STRB;
        end
      end
      ST_ADDR: state_d = ST_STRB;
      ST_STRB: begin
        if (strb_last) begin
          state_d = (req_q.write && hold_q) ? ST_HOLD : ST_END;
        end
      end
      ST_HOLD: begin
        if (hold_last) state_d = ST_END;
      end
      ST_END: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // strobe counter restarts on each timed state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_q <= 3'h0;
    else if (state_d != state_q) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end

  // request and modes frozen for the access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_q <= '0;
      mux_q <= 1'b0;
      wide_q <= 1'b0;
      hold_q <= 1'b0;
      async_q <= 1'b0;
    end else if (take) begin
      req_q <= req_i;
      mux_q <= mode_i.pin_sharing_select;
      wide_q <= mode_i.wide_bus_select;
      hold_q <= mode_i.write_strobe_hold;
      async_q <= mode_i.async_mode;
    end
  end

  // chip select low for the whole access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) chip_select_n_o <= 4'hF;
    else if (state_d == ST_IDLE || state_d == ST_END) begin
      chip_select_n_o <= 4'hF;
    end else begin
      chip_select_n_o <= ~(4'h1 << cur_req.cs);
    end
  end

  // address pins carry the address in every mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) ext_addr_pins_o <= '0;
    else ext_addr_pins_o <= apin;
  end

  // address valid only in the mux address phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) addr_valid_n_o <= 1'b1;
    else addr_valid_n_o <= state_d != ST_ADDR;
  end

  // strobes: write stays low through the hold phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
    end else begin
      write_strobe_n_o <= !(cur_req.write &&
        (state_d == ST_STRB || state_d == ST_HOLD));
      read_strobe_n_o <= !(!cur_req.write && state_d == ST_STRB);
    end
  end

  // data pins: address word first in mux mode, then data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_data_pins_o <= '0;
      ext_data_pins_oe_o <= '0;
    end else if (state_d == ST_ADDR) begin
      // address word goes out on the edge that takes the request
      ext_data_pins_o <= mux_word & drv_mask;
      ext_data_pins_oe_o <= drv_mask;
    end else if (cur_req.write &&
                 (state_d == ST_STRB || state_d == ST_HOLD)) begin
      ext_data_pins_o <= cur_req.wdata & drv_mask;
      ext_data_pins_oe_o <= drv_mask;
    end else begin
      ext_data_pins_o <= '0;
      ext_data_pins_oe_o <= '0;
    end
  end

  // async read data taken on the falling system clock edge
  always_ff @(negedge clk_i or negedge rstn_i) begin
    if (!rstn_i) rd_neg_q <= '0;
    else if (!read_strobe_n_o) rd_neg_q <= ext_data_pins_i;
  end

  // response: data at the end of the cycle, error for outside space
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_err_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= state_q == ST_END || (take && !in_win);
      rsp_err_o <= take && !in_win;
      if (state_q == ST_END && !req_q.write) begin
        rsp_rdata_o <= (async_q ? rd_neg_q : ext_data_pins_i)
          & half_mask;
      end
    end
  end

  // ---- assertions ----
  property p_clk_gate;
    @(posedge clk_i) disable iff (!rstn_i)
    mode_i.clk_gate_en && $stable(mode_i.clk_gate_en) &&
    state_q == ST_IDLE && $past(state_q) == ST_IDLE |=> !ext_bus_clock_o;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("bus clock ran outside chip select");

  property p_clk_late;
    @(posedge clk_i) disable iff (!rstn_i)
    mode_i.clk_gate_en && mode_i.clock_timing_select &&
    $past(state_q) == ST_IDLE && state_q != ST_IDLE |=> !ext_bus_clock_o;
  endproperty
  a_clk_late: assert property (p_clk_late)
    else $error("late timing let clock start early");

  property p_addr32;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q != ST_IDLE && wide_q |-> ext_addr_pins_o == req_q.addr[28:2];
  endproperty
  a_addr32: assert property (p_addr32)
    else $error("32-bit address pins wrong");

  property p_addr16;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q != ST_IDLE && !wide_q |-> ext_addr_pins_o == req_q.addr[27:1];
  endproperty
  a_addr16: assert property (p_addr16)
    else $error("16-bit address pins wrong");

  property p_upper_off;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q != ST_IDLE && !wide_q |-> ext_data_pins_oe_o[31:16] == 16'h0000;
  endproperty
  a_upper_off: assert property (p_upper_off)
    else $error("upper data pins driven on 16-bit bus");

  property p_mux32;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_ADDR && wide_q |->
      ext_data_pins_o == {`ESP_MUX_PAD, req_q.addr[28:2]} &&
      ext_data_pins_oe_o == 32'hFFFFFFFF;
  endproperty
  a_mux32: assert property (p_mux32)
    else $error("32-bit mux address word wrong");

  property p_mux16;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_ADDR && !wide_q |->
      ext_data_pins_o == {16'h0000, req_q.addr[16:1]};
  endproperty
  a_mux16: assert property (p_mux16)
    else $error("16-bit mux address word wrong");

  property p_sep_noadv;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q != ST_IDLE && !mux_q |-> addr_valid_n_o;
  endproperty
  a_sep_noadv: assert property (p_sep_noadv)
    else $error("address valid in separate mode");

  property p_adv_then_strobe;
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(addr_valid_n_o) |-> ext_data_pins_oe_o != '0 ##1
      (addr_valid_n_o && !(write_strobe_n_o && read_strobe_n_o));
  endproperty
  a_adv_then_strobe: assert property (p_adv_then_strobe)
    else $error("address phase not followed by strobe");

  property p_we_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(write_strobe_n_o) && hold_q |->
      (!write_strobe_n_o)[*4] ##1 write_strobe_n_o;
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("held write strobe length wrong");

  property p_we_norm;
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(write_strobe_n_o) && !hold_q |->
      (!write_strobe_n_o)[*2] ##1 write_strobe_n_o;
  endproperty
  a_we_norm: assert property (p_we_norm)
    else $error("normal write strobe length wrong");

  property p_async_rd;
    @(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_END && async_q && !req_q.write |=>
      rsp_valid_o && rsp_rdata_o == ($past(rd_neg_q) & half_mask);
  endproperty
  a_async_rd: assert property (p_async_rd)
    else $error("async read not from falling edge sample");

  property p_window;
    @(posedge clk_i) disable iff (!rstn_i)
    take && !in_win |=> rsp_err_o && rsp_valid_o && state_q == ST_IDLE;
  endproperty
  a_window: assert property (p_window)
    else $error("access outside external space not refused");

  c_mux_write: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_HOLD && mux_q);
  c_async_read: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_END && async_q && !req_q.write);
  c_sep_wide: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_q == ST_STRB && !mux_q && wide_q);
endmodule

// >>> core/esp_cfg.svh
// constants for the external sram pin interface
`ifndef ESP_CFG_SVH
`define ESP_CFG_SVH
// external window: 256 MB starting at 1000_0000h
`define ESP_WIN_BASE 4'h1
`define ESP_WIN_TOP_MSB 31
`define ESP_WIN_TOP_LSB 28
// strobe low time in system clocks
`define ESP_DATA_CYC 3'h2
// extra write strobe time when the hold bit is set
`define ESP_HOLD_CYC 3'h2
// pin widths
`define ESP_APIN_W 27
`define ESP_DPIN_W 32
`define ESP_HALF_W 16
// zero field placed above the word address on a 32-bit mux bus
`define ESP_MUX_PAD 5'h00
`endif

// >>> core/esp_pkg.sv
// types shared by the external sram pin interface
package esp_pkg;
  // access request from the system side
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0]  cs;
  } esp_req_t;
  // controller mode settings
  typedef struct packed {
    logic clk_gate_en;
    logic clock_timing_select;
    logic pin_sharing_select;
    logic wide_bus_select;
    logic write_strobe_hold;
    logic async_mode;
  } esp_mode_t;
  // bus cycle states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_STRB = 3'b010,
    ST_HOLD = 3'b011,
    ST_END  = 3'b100
  } esp_state_t;
endpackage

// >>> core/esp_addr_map.sv
// address placement on the address pins and the mux address word
`timescale 1ns/1ps
`include "esp_cfg.svh"
module esp_addr_map import esp_pkg::*; (
  // access address and bus width
  input  wire logic [31:0] addr_i,
  input  wire logic wide_i,
  // pin values
  output logic [`ESP_APIN_W-1:0] apin_o,
  output logic [`ESP_DPIN_W-1:0] mux_word_o
);
  // lowest valid address bit always lands on pin index 0
  always_comb begin
    if (wide_i) begin
      apin_o = addr_i[28:2];
      mux_word_o = {`ESP_MUX_PAD, addr_i[28:2]};
    end else begin
      apin_o = addr_i[27:1];
      mux_word_o = {16'h0000, addr_i[16:1]};
    end
  end
endmodule

// >>> core/esp_clk_gen.sv
// external bus clock: divide by two, optional chip-select gating
`timescale 1ns/1ps
module esp_clk_gen import esp_pkg::*; (
  // system clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // gating controls
  input  wire logic gate_en_i,
  input  wire logic late_i,
  input  wire logic cs_act_i,
  // bus clock pin
  output logic ext_bus_clock_o
);
  logic div_q; // free running divider phase
  logic cs_dly_q; // chip select window one clock late
  logic run; // clock allowed this cycle

  // divider toggles every system clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) div_q <= 1'b0;
    else div_q <= ~div_q;
  end

  // delayed window for the late timing
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cs_dly_q <= 1'b0;
    else cs_dly_q <= cs_act_i;
  end

  // timing select picks the window edge
  assign run = !gate_en_i || (late_i ? cs_dly_q : cs_act_i);

  // clock held low outside the window
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) ext_bus_clock_o <= 1'b0;
    else ext_bus_clock_o <= run & ~div_q;
  end
endmodule

// >>> testbench/esp_mem_model.sv
// behavioural external memory that answers the controller pins
`timescale 1ns/1ps
module esp_mem_model (
  // clock and bus mode
  input wire logic clk_i,
  input wire logic mux_i,
  input wire logic wide_i,
  // memory pins
  input wire logic [3:0] cs_n_i,
  input wire logic [26:0] apin_i,
  input wire logic [31:0] dpin_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic adv_n_i,
  output logic [31:0] dout_o
);
  logic [31:0] mem [16]; // small word store
  logic [3:0] lat_q; // address caught in the mux address phase
  logic [3:0] idx; // word picked for this access
  logic sel; // any chip select low
  assign sel = (cs_n_i != 4'hF);
  assign idx = mux_i ? lat_q : apin_i[3:0];
  initial dout_o = 32'h0;
  // latch the address word while address valid is low
  always @(posedge clk_i) begin
    if (!adv_n_i) lat_q <= dpin_i[3:0];
  end
  // store write data, only the low half on a narrow bus
  always @(posedge clk_i) begin
    if (sel && !we_n_i) begin
      mem[idx] <= wide_i ? dpin_i : {16'h0, dpin_i[15:0]};
    end
  end
  // registered read data; a released bus shows the inverse
  always @(posedge clk_i) begin
    dout_o <= (sel && !re_n_i) ? mem[idx] : ~dout_o;
  end
endmodule

// >>> testbench/ext_sram_pin_interface_test.sv
// self-checking bench for the external sram controller
`timescale 1ns/1ps
module ext_sram_pin_interface_test;
  import esp_pkg::*;
  logic clk_i = 1'b0; // 10 MHz system clock
  logic rstn_i = 1'b0;
  esp_mode_t mode_i = '0;
  logic req_valid_i = 1'b0;
  esp_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, rsp_err_o, ext_bus_clock_o;
  logic [31:0] rsp_rdata_o, dpo, oe, dpi, mem_q;
  logic [3:0] cs_n;
  logic [26:0] apin;
  logic we_n, re_n, adv_n;
  int error_cnt = 0;
  int checked = 0;
  // per access observations
  int wcnt, acnt, csl, fhi, h, f0, i, bsy;
  logic [31:0] rd, mword, apin_s, a, d;
  logic [15:0] oeup;
  logic er;
  // each data wire carries whoever drives it
  assign dpi = (dpo & oe) | (mem_q & ~oe);
  initial forever #50 clk_i = ~clk_i;
  esp_ctrl u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
    .rsp_rdata_o(rsp_rdata_o), .ext_bus_clock_o(ext_bus_clock_o),
    .chip_select_n_o(cs_n), .ext_addr_pins_o(apin),
    .ext_data_pins_o(dpo), .ext_data_pins_oe_o(oe),
    .ext_data_pins_i(dpi), .write_strobe_n_o(we_n),
    .read_strobe_n_o(re_n), .addr_valid_n_o(adv_n));
  esp_mem_model u_mem (.clk_i(clk_i), .mux_i(mode_i.pin_sharing_select),
    .wide_i(mode_i.wide_bus_select), .cs_n_i(cs_n), .apin_i(apin),
    .dpin_i(dpo), .we_n_i(we_n), .re_n_i(re_n), .adv_n_i(adv_n),
    .dout_o(mem_q));
  // compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one access: request for one clock, then watch pins until response
  task automatic xfer(input logic w, input logic [31:0] ad,
                      input logic [31:0] dt);
    int n;
    n = 0;
    wcnt = 0;
    acnt = 0;
    csl = 0;
    bsy = 0;
    fhi = 99;
    oeup = '0;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = {w, ad, dt, 2'h1};
    @(negedge clk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 20) begin
      n++;
      if (req_ready_o === 1'b0) bsy++;
      if (we_n === 1'b0) wcnt++;
      if (adv_n === 1'b0) begin
        acnt++;
        mword = dpo;
      end
      if (cs_n !== 4'hF) begin
        csl++;
        apin_s = apin;
        oeup = oeup | oe[31:16];
      end
      if (ext_bus_clock_o === 1'b1 && fhi == 99) fhi = n;
      @(negedge clk_i);
    end
    if (n == 20) error_cnt++;
    er = rsp_err_o;
    rd = rsp_rdata_o;
  endtask
  // bus clock highs over four idle cycles
  task automatic idle_hi(output int hc);
    hc = 0;
    repeat (2) @(negedge clk_i);
    repeat (4) begin
      @(negedge clk_i);
      if (ext_bus_clock_o === 1'b1) hc++;
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    chk({we_n, re_n, adv_n, cs_n}, 7'h7F);
    // every sharing and width setting, async reads on the wide bus
    for (i = 0; i < 4; i++) begin
      a = 32'h1B5A_C3C0 + 4 * i;
      d = 32'hA5C3_0F10 + i;
      mode_i = {2'b00, i[1], i[0], 1'b0, i[0]};
      xfer(1'b1, a, d);
      chk(apin_s, i[0] ? a[28:2] : a[27:1]);
      chk(wcnt, 2);
      chk(acnt, i[1]);
      chk(bsy, 3 + i[1]);
      if (!i[0]) chk(oeup, 16'h0000);
      if (i[1] && i[0]) chk(mword, {5'h00, a[28:2]});
      if (i[1] && !i[0]) chk(mword, {16'h0, a[16:1]});
      xfer(1'b0, a, 32'h0);
      chk(rd, i[0] ? d : {16'h0, d[15:0]});
      chk(er, 1'b0);
    end
    // stretched write strobe
    mode_i = 6'h02;
    xfer(1'b1, 32'h1000_0008, 32'h0000_5A5A);
    chk(wcnt, 4);
    chk(bsy, 5);
    // outside the external space: error, no chip select
    xfer(1'b1, 32'h2000_0000, 32'h1);
    chk({er, csl[7:0]}, 9'h100);
    chk(bsy, 0);
    xfer(1'b0, 32'h0FFF_FFFC, 32'h0);
    chk({er, csl[7:0]}, 9'h100);
    xfer(1'b1, 32'h1FFF_FFF0, 32'h1);
    chk(er, 1'b0);
    // bus clock free running, then gated to chip select
    mode_i = 6'h00;
    idle_hi(h);
    chk(h, 2);
    mode_i = 6'h20;
    idle_hi(h);
    chk(h, 0);
    xfer(1'b1, 32'h1000_0010, 32'h3);
    f0 = fhi;
    chk(f0 < 99, 1'b1);
    mode_i = 6'h30;
    xfer(1'b1, 32'h1000_0010, 32'h3);
    chk(fhi, f0 + 1);
    close_out();
  end
  // hang guard
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
endmodule
